/* File: rtl/wfe_error_tally.sv */
/*
  holds the frame error up/down counter with overflow detection.
  assumes error, good-frame and clear strobes are one-cycle pulses
  synchronous to clk, and that the limit is stable while counting.
*/
module wfe_error_tally #(
  parameter int unsigned WIDTH = 8  // counter width
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // frame events
  input  wire logic frame_error,     // stuff, crc or crc delimiter error
  input  wire logic frame_ok,        // correctly received frame
  input  wire logic frame_is_fd,     // frame was classified as fd
  input  wire logic fd_frames_ignored, // fd passive mode
  input  wire logic clear,           // restart count from zero
  input  wire logic [WIDTH-1:0] error_limit,
  // results
  output logic [WIDTH-1:0] frame_error_tally,
  output logic overflow_pulse        // one cycle per overflow
);

  // ----------------------------------------------------------------------
  // next-state computation
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] next_frame_error_tally; // next count
  logic next_overflow_pulse;                // next overflow strobe
  logic counts;                             // frame counts at all

  // up on error, down on good frame, fd frames skipped when passive
  always_comb begin
    counts = !(fd_frames_ignored && frame_is_fd);
    next_frame_error_tally = frame_error_tally;
    next_overflow_pulse = 1'b0;
    if (clear) begin
      // detection enabled or bus silence seen
      next_frame_error_tally = '0;
    end else if (counts && frame_error) begin
      if (frame_error_tally == error_limit) begin
        // one past the limit wraps and flags overflow
        next_frame_error_tally = '0;
        next_overflow_pulse = 1'b1;
      end else begin
        next_frame_error_tally =
          frame_error_tally + WIDTH'(1'b1);
      end
    end else if (counts && frame_ok && (frame_error_tally != '0)) begin
      next_frame_error_tally = frame_error_tally - WIDTH'(1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // plain state update
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_error_tally <= '0;
      overflow_pulse <= 1'b0;
    end else begin
      frame_error_tally <= next_frame_error_tally;
      overflow_pulse <= next_overflow_pulse;
    end
  end

endmodule

/* File: rtl/wfe_pkg.sv */
/*
  holds the register map, field positions and reset values shared by the
  wake frame-error and interrupt summary register bank.
  assumes an 8-bit register address space reached over a decoded
  byte-wide register port from the configuration serial interface.
*/
package wfe_pkg;

  // ----------------------------------------------------------------------
  // register widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;  // register address width
  localparam int unsigned DATA_W = 8;  // register data width

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_FRAME_ERROR_THRESHOLD = 8'h46;
  localparam logic [7:0] ADDR_WAKE_CONFIG_DONE_AND_SYNC = 8'h47;
  localparam logic [7:0] ADDR_WAKE_CONFIG_RESERVED_LO = 8'h48;
  localparam logic [7:0] ADDR_WAKE_CONFIG_RESERVED_HI = 8'h4F;
  localparam logic [7:0] ADDR_GLOBAL_INTERRUPT_SUMMARY = 8'h50;
  localparam logic [7:0] ADDR_FIRST_INTERRUPT = 8'h51;
  // wake configuration range whose writes drop the complete bit
  localparam logic [7:0] ADDR_WAKE_CFG_LO = 8'h30;
  localparam logic [7:0] ADDR_WAKE_CFG_HI = 8'h44;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_ERROR_LIMIT = 8'h1F;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_SETUP_COMPLETE = 7;  // in 0x47
  localparam int unsigned BIT_FD_LOCKED = 6;       // in 0x47
  localparam int unsigned BIT_CLASSIC_LOCKED = 5;  // in 0x47
  localparam int unsigned BIT_ANY_PENDING = 7;     // in 0x50
  localparam int unsigned BIT_FIRST_GROUP = 6;     // in 0x50
  localparam int unsigned BIT_SECOND_GROUP = 5;    // in 0x50
  localparam int unsigned BIT_THIRD_GROUP = 4;     // in 0x50
  localparam int unsigned BIT_BUS_FAULT_GROUP = 3; // in 0x50
  localparam int unsigned BIT_COUNTER_OVERFLOW = 3; // in 0x51
  localparam int unsigned BIT_WAKE_ERROR = 6;      // in third group

endpackage

/* File: rtl/wfe_reg_bank.sv */
/*
  holds the selective-wake frame-error threshold, the wake configuration
  complete and decode lock flags, the reserved block and the global
  interrupt summary, plus the counter overflow flag of the first group.
  assumes a decoded byte-wide register port, one access per cycle, and a
  frame decoder that gives one-cycle event pulses synchronous to clk.
*/


module wfe_reg_bank #(
  parameter int unsigned LIMIT_W = 8  // frame error counter width
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,

  // register port
  input  wire logic reg_wr,                 // write strobe
  input  wire logic reg_rd,                 // read strobe
  input  wire logic [7:0] reg_addr,         // register address
  input  wire logic [7:0] reg_wdata,        // write data
  output logic [7:0] reg_rdata,             // read data, valid after rd

  // frame decoder events
  input  wire logic frame_detect_enable,    // frame detection on
  input  wire logic silence_detected,       // bus silence timeout pulse
  input  wire logic frame_done,             // end of received frame
  input  wire logic frame_is_fd,            // that frame was fd
  input  wire logic frame_error,            // error frame pulse
  input  wire logic frame_ok,               // good frame pulse
  input  wire logic classic_decode_ok,      // decoder status classic
  input  wire logic fd_decode_ok,           // decoder status fd

  // configuration from other wake registers
  input  wire logic wake_filter_enable,     // software asks for wake
  input  wire logic fd_frames_ignored,      // fd passive mode

  // other interrupt flags of the device
  input  wire logic [7:0] first_group_flags,  // group one, bit 3 unused
  input  wire logic [7:0] second_group_flags, // group two
  input  wire logic [7:0] third_group_flags,  // group three, bit 6 unused
  input  wire logic [7:0] bus_fault_group_flags, // bus fault group

  // status toward the rest of the device
  output logic [LIMIT_W-1:0] frame_error_tally, // live counter
  output logic error_counter_overflow,      // latched overflow flag
  output logic wake_setup_complete,         // configuration complete
  output logic fd_decode_locked,            // fd decode in sync
  output logic classic_decode_locked,       // classic decode in sync
  output logic wake_error_status,           // wake error condition
  output logic wake_filter_active,          // wake allowed and asked
  output logic any_interrupt_pending,       // or of every flag
  output logic bus_fault_group_pending      // or of bus fault group
);

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  logic wr_limit;      // write to threshold
  logic wr_cfg4;       // write to complete/lock register
  logic wr_first_int;  // write to first interrupt group
  logic wr_wake_cfg;   // write to 0x30-0x44 or to the threshold

  // address decode for writes
  always_comb begin
    // one access per cycle
    wr_limit = reg_wr && (reg_addr == wfe_pkg::ADDR_FRAME_ERROR_THRESHOLD);
    wr_cfg4 = reg_wr &&
              (reg_addr == wfe_pkg::ADDR_WAKE_CONFIG_DONE_AND_SYNC);
    wr_first_int = reg_wr && (reg_addr == wfe_pkg::ADDR_FIRST_INTERRUPT);
    // range and threshold writes both count as wake setup
    wr_wake_cfg = reg_wr &&
                  (((reg_addr >= wfe_pkg::ADDR_WAKE_CFG_LO) &&
                    (reg_addr <= wfe_pkg::ADDR_WAKE_CFG_HI)) ||
                   (reg_addr == wfe_pkg::ADDR_FRAME_ERROR_THRESHOLD));
  end

  // ----------------------------------------------------------------------
  // frame error counter
  // ----------------------------------------------------------------------
  logic [LIMIT_W-1:0] error_limit;   // threshold register
  logic detect_enable_d;             // detection enable last cycle
  logic tally_clear;                 // restart the counter
  logic overflow_pulse;              // counter went past the limit

  // restart on the enabling edge or on silence
  always_comb begin
    tally_clear = (frame_detect_enable && !detect_enable_d) ||
                  silence_detected;
  end

  // up/down count with overflow
  wfe_error_tally #(
    .WIDTH(LIMIT_W)
  ) u_tally (
    .clk(clk),
    .sys_rst(sys_rst),
    .frame_error(frame_error),
    .frame_ok(frame_ok),
    .frame_is_fd(frame_is_fd),
    .fd_frames_ignored(fd_frames_ignored),
    .clear(tally_clear),
    .error_limit(error_limit),
    .frame_error_tally(frame_error_tally),
    .overflow_pulse(overflow_pulse)
  );

  // ----------------------------------------------------------------------
  // configuration and flag state
  // ----------------------------------------------------------------------
  // next values of the flags
  logic [LIMIT_W-1:0] next_error_limit;
  logic next_error_counter_overflow;
  logic next_wake_setup_complete;
  logic next_fd_decode_locked;
  logic next_classic_decode_locked;

  // software writes, hardware sets and clears
  always_comb begin
    next_error_limit = error_limit;
    next_error_counter_overflow = error_counter_overflow;
    next_wake_setup_complete = wake_setup_complete;
    next_fd_decode_locked = fd_decode_locked;
    next_classic_decode_locked = classic_decode_locked;

    // threshold is plain read/write
    if (wr_limit) begin
      next_error_limit = reg_wdata[LIMIT_W-1:0];
    end

    // complete bit: software write, dropped by wake setup writes
    if (wr_cfg4) begin
      next_wake_setup_complete =
        reg_wdata[wfe_pkg::BIT_SETUP_COMPLETE];
    end else if (wr_wake_cfg) begin
      next_wake_setup_complete = 1'b0;
    end

    // overflow flag: write one clears, a new overflow wins
    if (wr_first_int && reg_wdata[wfe_pkg::BIT_COUNTER_OVERFLOW]) begin
      next_error_counter_overflow = 1'b0;
    end
    if (overflow_pulse) begin
      next_error_counter_overflow = 1'b1;
    end

    // lock flags follow each frame, drop when detection is off
    if (!frame_detect_enable) begin
      next_fd_decode_locked = 1'b0;
      next_classic_decode_locked = 1'b0;
    end else if (frame_done) begin
      // fd flag wants a clean fd frame
      next_fd_decode_locked = frame_is_fd && fd_decode_ok;
      next_classic_decode_locked = classic_decode_ok;
    end
  end

  // register the configuration and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      error_limit <= wfe_pkg::RST_ERROR_LIMIT[LIMIT_W-1:0];
      error_counter_overflow <= 1'b0;
      wake_setup_complete <= 1'b0;
      fd_decode_locked <= 1'b0;
      classic_decode_locked <= 1'b0;
      detect_enable_d <= 1'b0;
    end else begin
      error_limit <= next_error_limit;
      error_counter_overflow <= next_error_counter_overflow;
      wake_setup_complete <= next_wake_setup_complete;
      fd_decode_locked <= next_fd_decode_locked;
      classic_decode_locked <= next_classic_decode_locked;
      // enable as seen last cycle
      detect_enable_d <= frame_detect_enable;
    end
  end

  // ----------------------------------------------------------------------
  // wake error and interrupt summary
  // ----------------------------------------------------------------------
  logic wake_err_now;          // live wake error condition
  logic [7:0] first_live;      // group one with own overflow bit
  logic [7:0] third_live;      // group three with own wake error bit
  logic [7:0] summary_live;    // summary register as read now
  // next values of the outputs
  logic next_wake_error_status;
  logic next_wake_filter_active;
  logic next_any_interrupt_pending;
  logic next_bus_fault_group_pending;

  // live or-terms from the current flag values
  always_comb begin
    wake_err_now = (wake_filter_enable && !wake_setup_complete) ||
                   error_counter_overflow;
    // own bits replace unused inputs
    first_live = first_group_flags;
    first_live[wfe_pkg::BIT_COUNTER_OVERFLOW] =
      error_counter_overflow;
    third_live = third_group_flags;
    third_live[wfe_pkg::BIT_WAKE_ERROR] = wake_err_now;

    // summary image, bits 2..0 stay zero
    summary_live = wfe_pkg::RST_ZERO;
    summary_live[wfe_pkg::BIT_FIRST_GROUP] = |first_live;
    summary_live[wfe_pkg::BIT_SECOND_GROUP] =
      |second_group_flags;
    summary_live[wfe_pkg::BIT_THIRD_GROUP] = |third_live;
    summary_live[wfe_pkg::BIT_BUS_FAULT_GROUP] =
      |bus_fault_group_flags;
    summary_live[wfe_pkg::BIT_ANY_PENDING] =
      |{first_live, second_group_flags, third_live,
        bus_fault_group_flags};

    // registered copies lag by a cycle
    next_wake_error_status = wake_err_now;
    // selective wake stays off while the error stands
    next_wake_filter_active = wake_filter_enable &&
                              !wake_err_now;
    next_any_interrupt_pending = summary_live[wfe_pkg::BIT_ANY_PENDING];
    next_bus_fault_group_pending =
      summary_live[wfe_pkg::BIT_BUS_FAULT_GROUP];
  end

  // register status outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_error_status <= 1'b0;
      wake_filter_active <= 1'b0;
      any_interrupt_pending <= 1'b0;
      bus_fault_group_pending <= 1'b0;
    end else begin
      wake_error_status <= next_wake_error_status;
      wake_filter_active <= next_wake_filter_active;
      any_interrupt_pending <= next_any_interrupt_pending;
      bus_fault_group_pending <= next_bus_fault_group_pending;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [7:0] next_reg_rdata;  // data captured on a read
  logic [7:0] cfg4_view;       // complete and lock register image

  // select the addressed register; unmapped reads give zero
  always_comb begin
    // complete and lock image
    cfg4_view = wfe_pkg::RST_ZERO;
    cfg4_view[wfe_pkg::BIT_SETUP_COMPLETE] = wake_setup_complete;
    cfg4_view[wfe_pkg::BIT_FD_LOCKED] = fd_decode_locked;
    cfg4_view[wfe_pkg::BIT_CLASSIC_LOCKED] = classic_decode_locked;

    // hold the last value between reads
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      next_reg_rdata = wfe_pkg::RST_ZERO;
      if (reg_addr == wfe_pkg::ADDR_FRAME_ERROR_THRESHOLD) begin
        next_reg_rdata[LIMIT_W-1:0] = error_limit;
      end else if (reg_addr ==
                   wfe_pkg::ADDR_WAKE_CONFIG_DONE_AND_SYNC) begin
        next_reg_rdata = cfg4_view;
      end else if ((reg_addr >= wfe_pkg::ADDR_WAKE_CONFIG_RESERVED_LO) &&
                   (reg_addr <= wfe_pkg::ADDR_WAKE_CONFIG_RESERVED_HI)) begin
        next_reg_rdata = wfe_pkg::RST_ZERO;
      end else if (reg_addr ==
                   wfe_pkg::ADDR_GLOBAL_INTERRUPT_SUMMARY) begin
        next_reg_rdata = summary_live;
      end else if (reg_addr == wfe_pkg::ADDR_FIRST_INTERRUPT) begin
        next_reg_rdata = first_live;
      end else begin
        next_reg_rdata = wfe_pkg::RST_ZERO;
      end
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= wfe_pkg::RST_ZERO;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

/* File: tb/testbench.sv */
/*
  self-checking bench for the wake frame-error register bank.
  assumes the host model on the register port and the bound checker.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic frame_detect_enable, silence_detected, frame_done, frame_is_fd;
  logic frame_error, frame_ok, classic_decode_ok, fd_decode_ok;
  logic wake_filter_enable, fd_frames_ignored;
  logic [7:0] g1, g2, g3, gb, tally;
  logic ovf, done_bit, fd_lk, cl_lk, werr, wact, anyp, busp;
  int n_errors, samples_checked, cycles;
  logic [7:0] cfg_addr [4] = '{8'h30, 8'h44, 8'h46, 8'h45};
  wfe_reg_bank uut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_detect_enable(frame_detect_enable),
    .silence_detected(silence_detected), .frame_done(frame_done),
    .frame_is_fd(frame_is_fd), .frame_error(frame_error),
    .frame_ok(frame_ok), .classic_decode_ok(classic_decode_ok),
    .fd_decode_ok(fd_decode_ok), .wake_filter_enable(wake_filter_enable),
    .fd_frames_ignored(fd_frames_ignored), .first_group_flags(g1),
    .second_group_flags(g2), .third_group_flags(g3),
    .bus_fault_group_flags(gb), .frame_error_tally(tally),
    .error_counter_overflow(ovf), .wake_setup_complete(done_bit),
    .fd_decode_locked(fd_lk), .classic_decode_locked(cl_lk),
    .wake_error_status(werr), .wake_filter_active(wact),
    .any_interrupt_pending(anyp), .bus_fault_group_pending(busp));
  wfe_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cr(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rv);
    chk($sformatf("reg %h", a), e, rv);
  endtask
  // one frame: error, good, fd qualifiers, then idle
  task automatic ev(input logic e, input logic ok, input logic fd);
    frame_error = e;
    frame_ok = ok;
    frame_is_fd = fd;
    frame_done = 1'b1;
    step(1);
    {frame_error, frame_ok, frame_done} = 3'h0;
    step(3);
  endtask
  task automatic t_count();
    frame_detect_enable = 1'b1;
    u_host.wr(8'h46, 8'h02);
    ev(1, 0, 0);
    ev(1, 0, 0);
    chk("tally", 8'h02, tally);
    chk("ovf", 8'h00, {7'h0, ovf});
    ev(1, 0, 0);
    chk("ovf", 8'h01, {7'h0, ovf});
    chk("any", 8'h01, {7'h0, anyp});
    cr(8'h51, 8'h08);
    cr(8'h50, 8'hD0);
    u_host.wr(8'h51, 8'h08);
    step(3);
    chk("ovf", 8'h00, {7'h0, ovf});
    ev(1, 0, 0);
    ev(0, 1, 0);
    ev(0, 1, 0);
    chk("tally", 8'h00, tally);
    fd_frames_ignored = 1'b1;
    ev(1, 0, 1);
    chk("tally", 8'h00, tally);
    fd_frames_ignored = 1'b0;
    ev(1, 0, 1);
    chk("tally", 8'h01, tally);
    silence_detected = 1'b1;
    step(1);
    silence_detected = 1'b0;
    step(2);
    chk("tally", 8'h00, tally);
    ev(1, 0, 0);
    frame_detect_enable = 1'b0;
    step(2);
    frame_detect_enable = 1'b1;
    step(3);
    chk("tally", 8'h00, tally);
  endtask
  task automatic t_config();
    ev(0, 1, 1);
    wake_filter_enable = 1'b1;
    step(4);
    chk("werr", 8'h01, {7'h0, werr});
    chk("wact", 8'h00, {7'h0, wact});
    u_host.config_wake(8'h1F);
    step(3);
    chk("werr", 8'h00, {7'h0, werr});
    chk("wact", 8'h01, {7'h0, wact});
    cr(8'h47, 8'hE0);
    foreach (cfg_addr[i]) begin
      u_host.wr(8'h47, 8'h80);
      u_host.wr(cfg_addr[i], 8'h1F);
      step(2);
      chk("done", {7'h0, cfg_addr[i] == 8'h45}, {7'h0, done_bit});
    end
    u_host.wr(8'h47, 8'h00);
    wake_filter_enable = 1'b0;
    cr(8'h47, 8'h60);
  endtask
  task automatic t_lock();
    fd_decode_ok = 1'b0;
    ev(0, 1, 1);
    cr(8'h47, 8'h20);
    classic_decode_ok = 1'b0;
    fd_decode_ok = 1'b1;
    ev(0, 1, 1);
    chk("lock", 8'h02, {6'h0, fd_lk, cl_lk});
    frame_detect_enable = 1'b0;
    step(3);
    cr(8'h47, 8'h00);
  endtask
  task automatic t_summary();
    {g1, g3} = {8'h08, 8'h40};
    cr(8'h50, 8'h00);
    gb = 8'h01;
    cr(8'h50, 8'h88);
    g2 = 8'h80;
    cr(8'h50, 8'hA8);
    {g1, g3} = {8'h01, 8'h01};
    u_host.wr(8'h50, 8'h00);
    cr(8'h50, 8'hF8);
    chk("pend", 8'h03, {6'h0, anyp, busp});
    for (int a = 8'h48; a <= 8'h4F; a++) begin
      u_host.wr(8'(a), 8'hFF);
      cr(8'(a), 8'h00);
    end
    {g1, g2, g3, gb} = 32'h0;
  endtask
  initial begin
    {n_errors, samples_checked, cycles} = 0;
    sys_rst = 1'b1;
    {frame_detect_enable, silence_detected, frame_done} = 3'h0;
    {frame_is_fd, frame_error, frame_ok, fd_frames_ignored} = 4'h0;
    {classic_decode_ok, fd_decode_ok, wake_filter_enable} = 3'h6;
    {g1, g2, g3, gb} = 32'h0;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    cr(8'h46, 8'h1F);
    cr(8'h47, 8'h00);
    cr(8'h50, 8'h00);
    t_count();
    t_config();
    t_lock();
    t_summary();
    results();
  end
endmodule

/* File: tb/wfe_chk_checker.sv */
/*
  port-level properties of the wake frame-error register bank.
  assumes it is bound to wfe_reg_bank and sees only that module's ports.
*/
module wfe_chk #(
  parameter int unsigned LIMIT_W = 8  // counter width
) (
  // clock, reset and register port
  input wire logic clk, sys_rst, reg_wr, reg_rd,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  // frame events and configuration
  input wire logic frame_detect_enable, silence_detected, frame_done,
  input wire logic frame_is_fd, frame_error, fd_decode_ok,
  input wire logic classic_decode_ok, fd_frames_ignored,
  input wire logic wake_filter_enable,
  input wire logic [7:0] second_group_flags, bus_fault_group_flags,
  // status outputs
  input wire logic [LIMIT_W-1:0] frame_error_tally,
  input wire logic error_counter_overflow, wake_setup_complete,
  input wire logic fd_decode_locked, classic_decode_locked,
  input wire logic wake_error_status, wake_filter_active,
  input wire logic any_interrupt_pending
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // shadow of the threshold, tracked from register writes
  // ----------------------------------------------------------------
  logic [7:0] lim;  // current limit
  logic [7:0] next_lim;  // limit after this cycle
  always_comb begin
    next_lim = lim;
    if (reg_wr && reg_addr == 8'h46) next_lim = reg_wdata;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) lim <= 8'h1F;
    else lim <= next_lim;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // an error that counts: no clear, not a passive fd frame
  sequence s_counted_err;
    frame_error && !silence_detected && $stable(frame_detect_enable)
      && !(frame_is_fd && fd_frames_ignored);
  endsequence
  property p_ovf;
    s_counted_err ##0 (frame_error_tally == LIMIT_W'(lim))
      |-> ##[2:3] error_counter_overflow;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag not raised at limit");
  property p_inc;
    s_counted_err ##0 (frame_error_tally != LIMIT_W'(lim))
      |=> frame_error_tally == LIMIT_W'($past(frame_error_tally) + 1);
  endproperty
  a_inc: assert property (p_inc)
    else $error("counter did not step up on error");
  property p_silence;
    silence_detected |=> frame_error_tally == '0;
  endproperty
  a_silence: assert property (p_silence)
    else $error("counter not cleared by silence");
  property p_cfg_set;
    reg_wr && reg_addr == 8'h47
      |=> wake_setup_complete == $past(reg_wdata[7]);
  endproperty
  a_cfg_set: assert property (p_cfg_set)
    else $error("complete bit not written");
  property p_cfg_clr;
    reg_wr && (reg_addr inside {[8'h30:8'h44], 8'h46})
      |=> !wake_setup_complete;
  endproperty
  a_cfg_clr: assert property (p_cfg_clr)
    else $error("complete bit kept after wake write");
  property p_lock;
    frame_done && frame_detect_enable |=> classic_decode_locked ==
      $past(classic_decode_ok) && fd_decode_locked ==
      ($past(frame_is_fd) && $past(fd_decode_ok));
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock flags not refreshed at frame end");
  property p_lock_off;
    !frame_detect_enable [*2] |-> !fd_decode_locked
      && !classic_decode_locked;
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("lock flags stay set with detection off");
  property p_rsvd;
    reg_rd && (reg_addr inside {[8'h48:8'h4F]}) |=> reg_rdata == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved location read nonzero");
  property p_sum;
    reg_rd && reg_addr == 8'h50 |=> reg_rdata[2:0] == 3'h0
      && reg_rdata[3] == ($past(bus_fault_group_flags) != 8'h00);
  endproperty
  a_sum: assert property (p_sum)
    else $error("summary read wrong in low bits");
  property p_any;
    (second_group_flags != 8'h00) [*2] |-> any_interrupt_pending;
  endproperty
  a_any: assert property (p_any)
    else $error("pending summary missing");
  property p_werr;
    (wake_filter_enable && !wake_setup_complete) [*3]
      |-> wake_error_status && !wake_filter_active;
  endproperty
  a_werr: assert property (p_werr)
    else $error("wake enabled without complete bit");
endmodule
bind wfe_reg_bank wfe_chk #(.LIMIT_W(LIMIT_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .frame_detect_enable(frame_detect_enable),
  .silence_detected(silence_detected), .frame_done(frame_done),
  .frame_is_fd(frame_is_fd), .frame_error(frame_error),
  .fd_decode_ok(fd_decode_ok), .classic_decode_ok(classic_decode_ok),
  .fd_frames_ignored(fd_frames_ignored),
  .wake_filter_enable(wake_filter_enable),
  .second_group_flags(second_group_flags),
  .bus_fault_group_flags(bus_fault_group_flags),
  .frame_error_tally(frame_error_tally),
  .error_counter_overflow(error_counter_overflow),
  .wake_setup_complete(wake_setup_complete),
  .fd_decode_locked(fd_decode_locked),
  .classic_decode_locked(classic_decode_locked),
  .wake_error_status(wake_error_status),
  .wake_filter_active(wake_filter_active),
  .any_interrupt_pending(any_interrupt_pending));

/* File: tb/wfe_host.sv */
/*
  host model driving the byte-wide register port.
  assumes the bench calls its tasks one at a time after a clock edge.
*/
module wfe_host (
  // clock
  input wire logic clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one write; idle bus shows inverted values so nothing stale is reused
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // one read; data is taken once it has settled a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge clk) #1;
    d = reg_rdata;
  endtask
  // wake setup: 0x44 and the threshold first, the complete bit last
  task automatic config_wake(input logic [7:0] lim);
    wr(8'h44, 8'h50);
    wr(8'h46, lim);
    wr(8'h47, 8'h80);
  endtask
endmodule
